// >>> design/pmed_ctrl.v
// Power mode and energy detect controller with its serial register port
`timescale 1ns/1ns
`include "pmed_regs.vh"

module pmed_ctrl #(
    parameter TICK_CYCLES = `PMED_TICK_US * `PMED_CLK_MHZ
) (
    input wire clk_i,
    input wire hw_reset_n_i,
    input wire sclk_i,
    input wire chip_select_n_i,
    input wire si_i,
    input wire eeprom_data_pin_i,
    input wire energy_i,
    input wire autoneg_en_i,
    input wire cable_present_i,
    output wire so_o,
    output wire so_oe_o,
    output reg host_irq_n_o,
    output reg wake_event_n_o,
    output reg [1:0] mode_o,
    output reg low_power_o,
    output reg pll_en_o,
    output reg mac_en_o,
    output reg phy_tx_en_o,
    output reg phy_rx_en_o,
    output reg energy_det_en_o,
    output reg host_if_ready_o,
    output reg pkt_en_o
);

    localparam ST_NORMAL = 1'b0;
    localparam ST_LOW = 1'b1;

    reg [15:0] ier_reg;
    reg [15:0] pmc_reg;
    reg [15:0] gsw_reg;
    reg [15:0] plc_reg;
    reg flag_ed_reg;
    reg eep_reg;
    reg [1:0] strap_cnt_reg;
    reg state_reg;
    reg state_next;
    reg evt_done_reg;
    reg [31:0] tick_cnt_reg;
    reg tick_reg;
    reg [8:0] unit_cnt_reg;
    reg [8:0] unit_cnt_next;
    reg wake_evt;
    reg clr_mode;
    reg eep_m;
    reg eep_s;
    reg en_m;
    reg en_s;
    reg an_m;
    reg an_s;
    reg cab_m;
    reg cab_s;

    wire cmd;
    wire [5:0] idx;
    wire [1:0] lane;
    wire wr;
    wire [7:0] wr_byte;
    reg [7:0] rd_byte;
    wire [7:0] reg_addr;
    wire [15:0] ccr_val;
    wire [15:0] flags_val;
    wire ed_mode;
    wire psave_mode;
    wire psave_active;

    assign reg_addr = {idx, lane[1], 1'b0};
    assign ccr_val = {6'h00, eep_reg, 9'h000};
    assign flags_val = {13'h0000, flag_ed_reg, 2'h0};
    assign ed_mode = (pmc_reg[`PMED_PMC_MODE] == `PMED_MODE_EDETECT);
    assign psave_mode = (pmc_reg[`PMED_PMC_MODE] == `PMED_MODE_PSAVE);
    // Saving only engages when every qualifier holds; otherwise full power
    assign psave_active = psave_mode & an_s & ~cab_s & plc_reg[`PMED_PLC_PSAVE];

    // ********************************
    // Serial register port
    // ********************************
    pmed_spi_slave u_spi (
        .clk_i(clk_i),
        .hw_reset_n_i(hw_reset_n_i),
        .sclk_i(sclk_i),
        .csn_i(chip_select_n_i),
        .si_i(si_i),
        .rd_byte_i(rd_byte),
        .cmd_o(cmd),
        .idx_o(idx),
        .lane_o(lane),
        .wr_o(wr),
        .wr_byte_o(wr_byte),
        .so_o(so_o),
        .so_oe_o(so_oe_o)
    );

    // Read path: each lane picks one byte of a 16-bit register
    always @* begin
        rd_byte = 8'h00;
        if (reg_addr == `PMED_OFS_IER) begin
            rd_byte = lane[0] ? ier_reg[15:8] : ier_reg[7:0];
        end else if (reg_addr == `PMED_OFS_FLAGS) begin
            rd_byte = lane[0] ? flags_val[15:8] : flags_val[7:0];
        end else if (reg_addr == `PMED_OFS_PMC) begin
            rd_byte = lane[0] ? pmc_reg[15:8] : pmc_reg[7:0];
        end else if (reg_addr == `PMED_OFS_GSW) begin
            rd_byte = lane[0] ? gsw_reg[15:8] : gsw_reg[7:0];
        end else if (reg_addr == `PMED_OFS_PLC) begin
            rd_byte = lane[0] ? plc_reg[15:8] : plc_reg[7:0];
        end else if (reg_addr == `PMED_OFS_CHIP_CFG) begin
            rd_byte = lane[0] ? ccr_val[15:8] : ccr_val[7:0];
        end
    end

    // ********************************
    // Pin synchronisers
    // ********************************
    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            eep_m <= 1'b0;
            eep_s <= 1'b0;
            en_m <= 1'b0;
            en_s <= 1'b0;
            an_m <= 1'b0;
            an_s <= 1'b0;
            cab_m <= 1'b0;
            cab_s <= 1'b0;
        end else begin
            eep_m <= eeprom_data_pin_i;
            eep_s <= eep_m;
            en_m <= energy_i;
            en_s <= en_m;
            an_m <= autoneg_en_i;
            an_s <= an_m;
            cab_m <= cable_present_i;
            cab_s <= cab_m;
        end
    end

    // ********************************
    // Strap capture after reset release
    // ********************************
    // The pin can only be sampled once the synchroniser has filled
    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            strap_cnt_reg <= 2'h0;
            eep_reg <= 1'b0;
        end else if (strap_cnt_reg < `PMED_STRAP_WAIT) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
        end else if (strap_cnt_reg == `PMED_STRAP_WAIT) begin
            eep_reg <= eep_s;
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
        end
    end

    // ********************************
    // Configuration registers
    // ********************************
    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            ier_reg <= `PMED_REG_RST;
            pmc_reg <= `PMED_REG_RST;
            gsw_reg <= `PMED_GSW_RST;
            plc_reg <= `PMED_REG_RST;
        end else begin
            if (wr) begin
                if (reg_addr == `PMED_OFS_IER) begin
                    if (lane[0]) ier_reg[15:8] <= wr_byte;
                    else ier_reg[7:0] <= wr_byte;
                end else if (reg_addr == `PMED_OFS_PMC) begin
                    if (lane[0]) pmc_reg[15:8] <= wr_byte;
                    else pmc_reg[7:0] <= wr_byte;
                end else if (reg_addr == `PMED_OFS_GSW) begin
                    if (lane[0]) gsw_reg[15:8] <= wr_byte;
                    else gsw_reg[7:0] <= wr_byte;
                end else if (reg_addr == `PMED_OFS_PLC) begin
                    if (lane[0]) plc_reg[15:8] <= wr_byte;
                    else plc_reg[7:0] <= wr_byte;
                end
            end
            // Wake to normal operation mode overrides a host write that cycle
            if (clr_mode) begin
                pmc_reg[1:0] <= `PMED_MODE_NORMAL;
            end
        end
    end

    // Energy flag: write one to clear, a new event in the same cycle wins
    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            flag_ed_reg <= 1'b0;
        end else if (wake_evt) begin
            flag_ed_reg <= 1'b1;
        end else if (wr && reg_addr == `PMED_OFS_FLAGS && !lane[0]
                     && wr_byte[`PMED_FLAG_ED]) begin
            flag_ed_reg <= 1'b0;
        end
    end

    // ********************************
    // Time base
    // ********************************
    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    // ********************************
    // Energy detect state machine
    // ********************************
    always @* begin
        state_next = state_reg;
        unit_cnt_next = unit_cnt_reg;
        wake_evt = 1'b0;
        clr_mode = 1'b0;
        case (state_reg)
            ST_NORMAL: begin
                if (!ed_mode || en_s) begin
                    unit_cnt_next = 9'h000;
                end else if (unit_cnt_reg > {1'b0, gsw_reg[`PMED_GSW_SLEEP]}) begin
                    state_next = ST_LOW;
                    unit_cnt_next = 9'h000;
                end else if (tick_reg) begin
                    unit_cnt_next = unit_cnt_reg + 9'h001;
                end
            end
            ST_LOW: begin
                if (!ed_mode) begin
                    state_next = ST_NORMAL;
                    unit_cnt_next = 9'h000;
                end else if (cmd && !pmc_reg[`PMED_PMC_AUTO]) begin
                    state_next = ST_NORMAL;
                    unit_cnt_next = 9'h000;
                end else if (!en_s || evt_done_reg) begin
                    unit_cnt_next = 9'h000;
                end else if (unit_cnt_reg > {1'b0, gsw_reg[`PMED_GSW_WAKE]}) begin
                    wake_evt = 1'b1;
                    unit_cnt_next = 9'h000;
                    if (pmc_reg[`PMED_PMC_AUTO]) begin
                        state_next = ST_NORMAL;
                        clr_mode = pmc_reg[`PMED_PMC_WAKE_NORM];
                    end
                end else if (tick_reg) begin
                    unit_cnt_next = unit_cnt_reg + 9'h001;
                end
            end
            default: begin
                state_next = ST_NORMAL;
                unit_cnt_next = 9'h000;
            end
        endcase
    end

    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            state_reg <= ST_NORMAL;
            unit_cnt_reg <= 9'h000;
            evt_done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            unit_cnt_reg <= unit_cnt_next;
            // One event per sleep; a host access ends the wait unless PMED_PMC_AUTO is set, when the event ends it
            if (state_next == ST_NORMAL) evt_done_reg <= 1'b0;
            else if (wake_evt) evt_done_reg <= 1'b1;
        end
    end

    // ********************************
    // Power enables and event pins
    // ********************************
    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            host_irq_n_o <= 1'b1;
            wake_event_n_o <= 1'b1;
            mode_o <= `PMED_MODE_NORMAL;
            low_power_o <= 1'b0;
            pll_en_o <= 1'b1;
            mac_en_o <= 1'b1;
            phy_tx_en_o <= 1'b1;
            phy_rx_en_o <= 1'b1;
            energy_det_en_o <= 1'b0;
            host_if_ready_o <= 1'b1;
            pkt_en_o <= 1'b1;
        end else begin
            host_irq_n_o <= ~(flag_ed_reg & ier_reg[`PMED_IER_ED]);
            wake_event_n_o <= ~(flag_ed_reg & pmc_reg[`PMED_PMC_EVT_EN]);
            mode_o <= pmc_reg[`PMED_PMC_MODE];
            low_power_o <= (state_reg == ST_LOW);
            // Mode 10 falls through to full power like mode 00
            pll_en_o <= (state_reg == ST_NORMAL);
            mac_en_o <= (state_reg == ST_NORMAL);
            host_if_ready_o <= (state_reg == ST_NORMAL);
            phy_tx_en_o <= (state_reg == ST_NORMAL);
            phy_rx_en_o <= (state_reg == ST_NORMAL) && !psave_active;
            energy_det_en_o <= ed_mode | psave_active | (state_reg == ST_LOW);
            pkt_en_o <= (state_reg == ST_NORMAL) && !psave_active;
        end
    end

endmodule

// >>> design/pmed_regs.vh
// Register map, field positions and constants for the power mode controller
`ifndef PMED_REGS_VH
`define PMED_REGS_VH

// ********************************
// Register byte offsets
// ********************************
`define PMED_OFS_CHIP_CFG 8'h08
`define PMED_OFS_IER 8'h90
`define PMED_OFS_FLAGS 8'h92
`define PMED_OFS_PMC 8'hD4
`define PMED_OFS_GSW 8'hD8
`define PMED_OFS_PLC 8'hF4

// ********************************
// Field positions
// ********************************
`define PMED_PMC_MODE 1:0
`define PMED_PMC_WAKE_NORM 6
`define PMED_PMC_AUTO 7
`define PMED_PMC_EVT_EN 8
`define PMED_IER_ED 2
`define PMED_FLAG_ED 2
`define PMED_PLC_PSAVE 10
`define PMED_CCR_EEP 9
`define PMED_GSW_SLEEP 7:0
`define PMED_GSW_WAKE 15:8

// ********************************
// Encodings and reset values
// ********************************
`define PMED_MODE_NORMAL 2'h0
`define PMED_MODE_EDETECT 2'h1
`define PMED_MODE_PSAVE 2'h3
`define PMED_OP_RD 2'h0
`define PMED_OP_WR 2'h1
`define PMED_REG_RST 16'h0000
`define PMED_GSW_RST 16'h0808
`define PMED_STRAP_WAIT 2'h2

// ********************************
// Timing
// ********************************
`define PMED_CLK_MHZ 50
`define PMED_TICK_US 1000

`endif

// >>> design/pmed_spi_slave.v
// Serial register port: command decode, byte lanes and serial data out
`timescale 1ns/1ns
`include "pmed_regs.vh"

module pmed_spi_slave (
    input wire clk_i,
    input wire hw_reset_n_i,
    input wire sclk_i,
    input wire csn_i,
    input wire si_i,
    input wire [7:0] rd_byte_i,
    output reg cmd_o,
    output reg [5:0] idx_o,
    output reg [1:0] lane_o,
    output reg wr_o,
    output reg [7:0] wr_byte_o,
    output reg so_o,
    output reg so_oe_o
);

    reg sclk_m;
    reg sclk_s;
    reg sclk_d;
    reg csn_m;
    reg csn_s;
    reg si_m;
    reg si_s;
    reg in_cmd;
    reg [3:0] cmd_cnt;
    reg [2:0] bit_cnt;
    reg [3:0] rem;
    reg op_wr;
    reg load_pend;
    reg [15:0] shift_in;
    reg [7:0] out_sr;
    reg [3:0] rem_n;
    wire rise;
    wire fall;
    wire [15:0] cmd_w;

    function [1:0] first_lane;
        input [3:0] m;
        begin
            first_lane = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
        end
    endfunction

    assign rise = sclk_s & ~sclk_d;
    assign fall = ~sclk_s & sclk_d;
    assign cmd_w = {shift_in[14:0], si_s};

    always @* begin
        rem_n = rem & ~(4'h1 << lane_o);
    end

    // ********************************
    // Pin synchronisers
    // ********************************
    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            csn_m <= 1'b1;
            csn_s <= 1'b1;
            si_m <= 1'b0;
            si_s <= 1'b0;
        end else begin
            sclk_m <= sclk_i;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            csn_m <= csn_i;
            csn_s <= csn_m;
            si_m <= si_i;
            si_s <= si_m;
        end
    end

    // ********************************
    // Frame engine, mode 0: sample on rise, shift out on fall
    // ********************************
    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            in_cmd <= 1'b1;
            cmd_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            rem <= 4'h0;
            op_wr <= 1'b0;
            load_pend <= 1'b0;
            shift_in <= 16'h0000;
            out_sr <= 8'h00;
            cmd_o <= 1'b0;
            idx_o <= 6'h00;
            lane_o <= 2'h0;
            wr_o <= 1'b0;
            wr_byte_o <= 8'h00;
            so_o <= 1'b1;
            so_oe_o <= 1'b0;
        end else begin
            cmd_o <= 1'b0;
            wr_o <= 1'b0;
            if (csn_s) begin
                in_cmd <= 1'b1;
                cmd_cnt <= 4'h0;
                bit_cnt <= 3'h0;
                rem <= 4'h0;
                load_pend <= 1'b0;
                so_o <= 1'b1;
                so_oe_o <= 1'b0;
            end else begin
                so_oe_o <= 1'b1;
                // Lane moves on only after the write strobe has used the old one
                if (load_pend) lane_o <= first_lane(rem);
                if (rise) begin
                    shift_in <= cmd_w;
                    if (in_cmd) begin
                        cmd_cnt <= cmd_cnt + 4'h1;
                        if (cmd_cnt == 4'hF) begin
                            in_cmd <= 1'b0;
                            op_wr <= (cmd_w[15:14] == `PMED_OP_WR);
                            idx_o <= cmd_w[9:4];
                            // Queue commands carry no lanes here and are dropped
                            if (cmd_w[15:14] == `PMED_OP_RD || cmd_w[15:14] == `PMED_OP_WR) begin
                                rem <= cmd_w[13:10];
                                lane_o <= first_lane(cmd_w[13:10]);
                                cmd_o <= 1'b1;
                                load_pend <= 1'b1;
                            end
                        end
                    end else if (rem != 4'h0) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            wr_o <= op_wr;
                            wr_byte_o <= cmd_w[7:0];
                            rem <= rem_n;
                            load_pend <= 1'b1;
                        end
                    end
                end
                if (fall) begin
                    if (load_pend) begin
                        out_sr <= rd_byte_i;
                        so_o <= rd_byte_i[7];
                        load_pend <= 1'b0;
                    end else begin
                        out_sr <= {out_sr[6:0], 1'b0};
                        so_o <= out_sr[6];
                    end
                end
            end
        end
    end

endmodule

// >>> test/pmed_ctrl_sva.sv
// Concurrent checks on the power mode controller ports
`timescale 1ns/1ns

module pmed_ctrl_sva #(
    parameter TICK_CYCLES = 4
) (
    input wire clk_i,
    input wire hw_reset_n_i,
    input wire chip_select_n_i,
    input wire so_oe_o,
    input wire host_irq_n_o,
    input wire wake_event_n_o,
    input wire [1:0] mode_o,
    input wire low_power_o,
    input wire pll_en_o,
    input wire mac_en_o,
    input wire phy_tx_en_o,
    input wire phy_rx_en_o,
    input wire energy_det_en_o,
    input wire host_if_ready_o,
    input wire pkt_en_o
);
    // ****************************************
    // Cycles since the last selected frame
    // ****************************************
    reg [3:0] cs_idle_reg;
    always @(posedge clk_i or negedge hw_reset_n_i) begin
        if (!hw_reset_n_i) begin
            cs_idle_reg <= 4'hF;
        end else if (!chip_select_n_i) begin
            cs_idle_reg <= 4'h0;
        end else if (cs_idle_reg != 4'hF) begin
            cs_idle_reg <= cs_idle_reg + 4'h1;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!hw_reset_n_i);

    a_reset_mode_zero: assert property ($rose(hw_reset_n_i) |-> mode_o == 2'h0 && !low_power_o)
        else $error("mode not normal after reset");
    a_normal_all_on: assert property ((mode_o != 2'h1 && $past(mode_o) != 2'h1) |->
        !low_power_o && pll_en_o && mac_en_o && host_if_ready_o)
        else $error("normal mode without full power");
    a_mode_src_host: assert property ($changed(mode_o) |-> cs_idle_reg < 4'hC || mode_o == 2'h0)
        else $error("mode changed without host write");
    a_sleep_in_detect: assert property ($rose(low_power_o) |-> mode_o == 2'h1)
        else $error("low power outside energy detect mode");
    a_low_power_gate: assert property (low_power_o |-> !pll_en_o && !mac_en_o && !phy_tx_en_o
        && !host_if_ready_o && !pkt_en_o && energy_det_en_o)
        else $error("block left on in low power");
    a_pkt_gate_on: assert property (pkt_en_o |-> !low_power_o && phy_rx_en_o && pll_en_o)
        else $error("packets allowed while powered down");
    a_save_gate_rx: assert property ($fell(phy_rx_en_o) |-> low_power_o || mode_o == 2'h3)
        else $error("receiver off without power saving");
    a_event_clear_host: assert property ($rose(wake_event_n_o) |-> cs_idle_reg < 4'hC)
        else $error("event pin released without host access");
    a_irq_clear_host: assert property ($rose(host_irq_n_o) |-> cs_idle_reg < 4'hC)
        else $error("interrupt released without host access");
    a_so_hiz_idle: assert property (chip_select_n_i [*4] |-> !so_oe_o)
        else $error("serial out driven while deselected");
endmodule

bind pmed_ctrl pmed_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) u_pmed_ctrl_sva (
    .clk_i(clk_i),
    .hw_reset_n_i(hw_reset_n_i),
    .chip_select_n_i(chip_select_n_i),
    .so_oe_o(so_oe_o),
    .host_irq_n_o(host_irq_n_o),
    .wake_event_n_o(wake_event_n_o),
    .mode_o(mode_o),
    .low_power_o(low_power_o),
    .pll_en_o(pll_en_o),
    .mac_en_o(mac_en_o),
    .phy_tx_en_o(phy_tx_en_o),
    .phy_rx_en_o(phy_rx_en_o),
    .energy_det_en_o(energy_det_en_o),
    .host_if_ready_o(host_if_ready_o),
    .pkt_en_o(pkt_en_o)
);

// >>> test/pmed_host_model.sv
// Host processor model: serial register master, clock idle low, MSB first
`timescale 1ns/1ns

module pmed_host_model (
    input wire clk_i,
    input wire so_i,
    output reg sclk_o,
    output reg csn_o,
    output reg si_o
);
    initial begin
        sclk_o = 1'b0;
        csn_o = 1'b1;
        si_o = 1'b0;
    end

    // 80 ns per phase: well under the 40 MHz ceiling, four system clocks each
    task bit_x(input d, output q);
        begin
            si_o = d;
            repeat (4) @(negedge clk_i);
            q = so_i;
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
        end
    endtask

    task xfer(input wr, input [7:0] addr, input [3:0] be, input [31:0] wd, output [31:0] rd);
        reg [15:0] cmd;
        reg q;
        integer i;
        integer k;
        begin
            cmd = {1'b0, wr, be, addr[7:2], 4'h0};
            rd = 32'h0;
            @(negedge clk_i);
            csn_o = 1'b0;
            repeat (4) @(negedge clk_i);
            for (i = 15; i >= 0; i = i - 1) begin
                bit_x(cmd[i], q);
            end
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    for (k = 7; k >= 0; k = k - 1) begin
                        bit_x(wd[8 * i + k], q);
                        rd[8 * i + k] = q;
                    end
                end
            end
            repeat (2) @(negedge clk_i);
            csn_o = 1'b1;
            // A deselected line must not look like it still holds data
            si_o = ~si_o;
            repeat (6) @(negedge clk_i);
        end
    endtask
endmodule

// >>> test/test_pmed_ctrl.sv
// Self-checking testbench for the power mode controller
`timescale 1ns/1ns
`include "pmed_regs.vh"

module test_pmed_ctrl;
    localparam TICK = 4;
    localparam [7:0] IRQ_EN_OFS = 8'h90;
    reg clk_i;
    reg hw_reset_n_i;
    reg eeprom_data_pin_i;
    reg energy_i;
    reg autoneg_en_i;
    reg cable_present_i;
    wire sclk_i, chip_select_n_i, si_i, so_o, so_oe_o, so_line;
    wire host_irq_n_o, wake_event_n_o, low_power_o, pll_en_o, mac_en_o;
    wire phy_tx_en_o, phy_rx_en_o, energy_det_en_o, host_if_ready_o, pkt_en_o;
    wire [1:0] mode_o;
    integer errors;
    integer total_checks;
    reg [31:0] rd;

    // External pull-up holds the line high while undriven
    assign so_line = so_oe_o ? so_o : 1'b1;

    pmed_ctrl #(.TICK_CYCLES(TICK)) u_pmed_ctrl (
        .clk_i(clk_i), .hw_reset_n_i(hw_reset_n_i), .sclk_i(sclk_i), .chip_select_n_i(chip_select_n_i),
        .si_i(si_i), .eeprom_data_pin_i(eeprom_data_pin_i), .energy_i(energy_i),
        .autoneg_en_i(autoneg_en_i), .cable_present_i(cable_present_i), .so_o(so_o),
        .so_oe_o(so_oe_o), .host_irq_n_o(host_irq_n_o), .wake_event_n_o(wake_event_n_o),
        .mode_o(mode_o), .low_power_o(low_power_o), .pll_en_o(pll_en_o), .mac_en_o(mac_en_o),
        .phy_tx_en_o(phy_tx_en_o), .phy_rx_en_o(phy_rx_en_o),
        .energy_det_en_o(energy_det_en_o), .host_if_ready_o(host_if_ready_o),
        .pkt_en_o(pkt_en_o)
    );

    pmed_host_model u_pmed_host_model (
        .clk_i(clk_i), .so_i(so_line), .sclk_o(sclk_i), .csn_o(chip_select_n_i), .si_o(si_i)
    );

    // ****************************************
    // Shared helpers
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task close_out;
        begin
            $display("checks %0d errors %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask

    task wr16(input [7:0] a, input [15:0] d);
        reg [31:0] r;
        begin
            u_pmed_host_model.xfer(1'b1, a, 4'b0011 << a[1:0], {16'h0, d} << (8 * a[1:0]), r);
        end
    endtask

    task rd16(input [7:0] a, output [15:0] d);
        reg [31:0] r;
        begin
            u_pmed_host_model.xfer(1'b0, a, 4'b0011 << a[1:0], 32'h0, r);
            r = r >> (8 * a[1:0]);
            d = r[15:0];
        end
    endtask

    task wait_lp(input v, output integer n);
        begin
            n = 0;
            while (low_power_o !== v && n < 400) begin
                @(negedge clk_i);
                n = n + 1;
            end
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset(input ev);
        reg [15:0] d;
        begin
            eeprom_data_pin_i = ev;
            hw_reset_n_i = 1'b0;
            repeat (8) @(negedge clk_i);
            hw_reset_n_i = 1'b1;
            repeat (4) @(negedge clk_i);
            chk(mode_o, 2'h0);
            chk({pll_en_o, mac_en_o, phy_tx_en_o, phy_rx_en_o, host_if_ready_o, pkt_en_o,
                low_power_o, energy_det_en_o}, 8'hFC);
            chk({so_oe_o, host_irq_n_o, wake_event_n_o}, 3'h3);
            rd16(`PMED_OFS_CHIP_CFG, d);
            chk(d[9], ev);
            rd16(`PMED_OFS_PMC, d);
            chk(d, 16'h0000);
            rd16(`PMED_OFS_GSW, d);
            chk(d, 16'h0808);
            u_pmed_host_model.xfer(1'b0, IRQ_EN_OFS, 4'hF, 32'h0, rd);
            chk(rd, 32'h0);
            rd16(8'h40, d);
            chk(d, 16'h0000);
        end
    endtask

    task t_modes;
        begin
            u_pmed_host_model.xfer(1'b1, `PMED_OFS_PMC, 4'h1, 32'h02, rd);
            chk(mode_o, 2'h2);
            chk({pll_en_o, mac_en_o, phy_rx_en_o, pkt_en_o, low_power_o}, 5'h1E);
            autoneg_en_i = 1'b1;
            cable_present_i = 1'b0;
            wr16(`PMED_OFS_PLC, 16'h0400);
            u_pmed_host_model.xfer(1'b1, `PMED_OFS_PMC, 4'h1, 32'h03, rd);
            chk(mode_o, 2'h3);
            chk({pll_en_o, phy_rx_en_o, pkt_en_o}, 3'h4);
            cable_present_i = 1'b1;
            repeat (8) @(negedge clk_i);
            chk({phy_rx_en_o, pkt_en_o}, 2'h3);
            cable_present_i = 1'b0;
            repeat (8) @(negedge clk_i);
            chk({phy_rx_en_o, pkt_en_o}, 2'h0);
            wr16(`PMED_OFS_PLC, 16'h0000);
            chk({phy_rx_en_o, pkt_en_o}, 2'h3);
            wr16(`PMED_OFS_PMC, 16'h0000);
            chk(mode_o, 2'h0);
            autoneg_en_i = 1'b0;
            cable_present_i = 1'b1;
        end
    endtask

    task t_sleep(input [15:0] pmc, input [15:0] ien);
        reg [15:0] d;
        integer n;
        begin
            wr16(`PMED_OFS_GSW, 16'h0302);
            wr16(IRQ_EN_OFS, ien);
            wr16(`PMED_OFS_PMC, pmc);
            chk(mode_o, 2'h1);
            energy_i = 1'b0;
            wait_lp(1'b1, n);
            chk(n >= 9 && n <= 24, 1'b1);
            chk({pll_en_o, mac_en_o, phy_tx_en_o, host_if_ready_o, pkt_en_o, energy_det_en_o},
                6'h01);
            energy_i = 1'b1;
            repeat (10) @(negedge clk_i);
            chk(low_power_o, 1'b1);
            if (pmc[7]) begin
                wait_lp(1'b0, n);
                chk(n <= 40, 1'b1);
            end else begin
                repeat (40) @(negedge clk_i);
                chk(low_power_o, 1'b1);
            end
            repeat (3) @(negedge clk_i);
            chk({host_irq_n_o, wake_event_n_o}, {~ien[2], ~pmc[8]});
            // The host answers the event with a register read
            rd16(`PMED_OFS_FLAGS, d);
            chk(d[2], 1'b1);
            chk(low_power_o, 1'b0);
            chk(mode_o, (pmc[7] & pmc[6]) ? 2'h0 : 2'h1);
            wr16(`PMED_OFS_FLAGS, 16'h0004);
            chk({host_irq_n_o, wake_event_n_o}, 2'h3);
            wr16(`PMED_OFS_PMC, 16'h0000);
        end
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        errors = 0;
        total_checks = 0;
        hw_reset_n_i = 1'b0;
        eeprom_data_pin_i = 1'b1;
        energy_i = 1'b1;
        autoneg_en_i = 1'b0;
        cable_present_i = 1'b1;
        t_reset(1'b1);
        t_modes;
        t_sleep(16'h0181, 16'h0004);
        t_sleep(16'h01C1, 16'h0000);
        t_sleep(16'h0101, 16'h0004);
        t_reset(1'b0);
        close_out;
    end

    // About 9200 cycles are expected; the limit leaves a wide margin
    initial begin
        #1000000;
        errors = errors + 1;
        close_out;
    end
endmodule
